// >>> core/qdurc_consts.vh
// Purpose: constants for the quad converter update and reset control
// Assumes: 24-bit command words, four channels
// Notes: timing counts derived from a 100 MHz clock
`ifndef QDURC_CONSTS_VH
`define QDURC_CONSTS_VH
`define QDURC_WORD_W 24
`define QDURC_CMD_MSB 23
`define QDURC_CMD_LSB 20
`define QDURC_ADDR_MSB 19
`define QDURC_ADDR_LSB 16
`define QDURC_DATA_MSB 15
`define QDURC_CMD_W_INPUT 4'h1
`define QDURC_CMD_UPD_OUT 4'h2
`define QDURC_CMD_W_BOTH 4'h3
`define QDURC_CMD_MASK 4'h5
`define QDURC_CMD_SW_RESET 4'h6
`define QDURC_MASK_RESET 4'h0
`define QDURC_RESET_MIN_NS 30
`define QDURC_CLK_NS 10
`define QDURC_RESET_CYC ((`QDURC_RESET_MIN_NS + `QDURC_CLK_NS - 1) / `QDURC_CLK_NS)
`define QDURC_POR_CYC 8
`endif

// >>> core/qdurc_ctrl.v
// Purpose: input/output register pairs, load mask, strobe and reset handling
// Assumes: the serial front end delivers a full 24-bit word with a one-cycle valid
// Notes: pins load_strobe_n, reset_n and reset_level_select are synchronised here
`include "qdurc_consts.vh"

//Contract
//- word is 24 bits: command nibble on top, address, then data, msb first.
//- each channel has input and output register; output drives the analog stage.
//- strobe low on write-to-input updates input and output at word end.
//- strobe high updates input only; later strobe fall copies unmasked channels.
//- command 0101 loads low four data bits into mask; address ignored.
//- mask bit 3 is channel D down to bit 0 channel A.
//- mask resets to zero; zero lets the strobe work normally.
//- masked channel ignores strobe transitions, sees strobe as high; code still updates it on write-to-input while strobe is held low.
//- strobe falling edge outside reset copies unmasked input registers to outputs.
//- strobe held low disregards mask so write-to-input updates outputs directly.
//- command 0010 copies input to output of addressed channel only.
//- command 0011 writes both input and output regardless of strobe.
//- reset pin low clears outputs to zero or midscale per select pin.
//- no output updates while reset low; cleared value held after release.
//- command 0110 performs software reset to power-on code.
//- strobe activity ignored during power-on reset.
//- reset pin low at power-up defers initialisation until release.
//- power-up output is zero scale if select low, midscale if high.
//- outputs hold reset level until first valid write.
module qdurc_ctrl #(
  parameter DATA_W = 16,
  parameter POR_CYC = `QDURC_POR_CYC
) (
  input wire clock,
  input wire rstn,
  input wire [`QDURC_WORD_W-1:0] cmd_word,
  input wire cmd_valid,
  input wire load_strobe_n,
  input wire reset_n,
  input wire reset_level_select,
  output wire cmd_ready,
  output reg [DATA_W-1:0] out_a_ff,
  output reg [DATA_W-1:0] out_b_ff,
  output reg [DATA_W-1:0] out_c_ff,
  output reg [DATA_W-1:0] out_d_ff,
  output reg [3:0] channel_load_mask_ff,
  output reg por_busy_ff
);

  // one-hot states
  localparam ST_POR = 3'h1;
  localparam ST_RUN = 3'h2;
  localparam ST_HOLD = 3'h4;

  function [DATA_W-1:0] reset_code;
    input sel;
    begin
      reset_code = {DATA_W{1'b0}};
      reset_code[DATA_W-1] = sel;
    end
  endfunction

  // take the pin level once stages 2 and 3 agree
  function filt;
    input [2:0] sync;
    input cur;
    begin
      if (sync[1] == sync[2])
        filt = sync[2];
      else
        filt = cur;
    end
  endfunction

  // one-hot channel select, bit 0 is channel A
  function ch_hit;
    input [3:0] sel;
    input integer k;
    begin
      ch_hit = sel[k];
    end
  endfunction

  reg [2:0] ld_sync_ff;
  reg [2:0] rs_sync_ff;
  reg [2:0] sel_sync_ff;
  // filtered pin levels
  reg ld_ff;
  reg rst_ff;
  reg sel_ff;
  reg ld_prev_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] por_cnt_ff;
  // channel register pairs
  reg [DATA_W-1:0] in_ff [0:3];
  reg [DATA_W-1:0] out_ff [0:3];
  reg [DATA_W-1:0] nxt_in [0:3];
  reg [DATA_W-1:0] nxt_out [0:3];
  reg [3:0] nxt_mask;
  // decoded command fields
  reg [3:0] sel_ch;
  reg [3:0] cmd;
  reg [DATA_W-1:0] dval;
  reg ld_fall;
  reg [3:0] ld_copy;
  reg do_clear;
  integer i;
  integer j;

  // words offered outside run are dropped
  assign cmd_ready = (state_ff == ST_RUN);

  // pin synchronisers, change counts once stages 2 and 3 agree
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      ld_sync_ff <= 3'h7;
      rs_sync_ff <= 3'h7;
      sel_sync_ff <= 3'h0;
      ld_ff <= 1'b1;
      rst_ff <= 1'b1;
      sel_ff <= 1'b0;
      ld_prev_ff <= 1'b1;
    end
    else
    begin
      ld_sync_ff <= {ld_sync_ff[1:0], load_strobe_n};
      rs_sync_ff <= {rs_sync_ff[1:0], reset_n};
      sel_sync_ff <= {sel_sync_ff[1:0], reset_level_select};
      ld_ff <= filt(ld_sync_ff, ld_ff);
      rst_ff <= filt(rs_sync_ff, rst_ff);
      sel_ff <= filt(sel_sync_ff, sel_ff);
      ld_prev_ff <= ld_ff;
    end
  end

  always @*
  begin
    cmd = cmd_word[`QDURC_CMD_MSB:`QDURC_CMD_LSB];
    dval = cmd_word[`QDURC_DATA_MSB:`QDURC_DATA_MSB-DATA_W+1];
    sel_ch = cmd_word[`QDURC_ADDR_MSB:`QDURC_ADDR_LSB];
    ld_fall = ld_prev_ff & ~ld_ff;
  end

  always @*
  begin
    ld_copy = {4{ld_fall}} & ~channel_load_mask_ff;
    if (state_ff != ST_RUN || !rst_ff)
      ld_copy = 4'h0;
  end

  // next state and register values
  always @*
  begin
    nxt_state = state_ff;
    nxt_mask = channel_load_mask_ff;
    do_clear = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      nxt_in[i] = in_ff[i];
      nxt_out[i] = out_ff[i];
    end
    case (state_ff)
      ST_POR:
      begin
        do_clear = 1'b1;
        if (rst_ff && (por_cnt_ff == 8'h00))
          nxt_state = ST_RUN;
      end
      ST_HOLD:
      begin
        do_clear = 1'b1;
        if (rst_ff)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!rst_ff)
        begin
          do_clear = 1'b1;
          nxt_state = ST_HOLD;
        end
        else
        begin
          for (i = 0; i < 4; i = i + 1)
            if (ld_copy[i])
              nxt_out[i] = in_ff[i];
          if (cmd_valid)
          begin
            case (cmd)
              `QDURC_CMD_W_INPUT:
              begin
                for (i = 0; i < 4; i = i + 1)
                  if (ch_hit(sel_ch, i))
                  begin
                    nxt_in[i] = dval;
                    if (!ld_ff)
                      nxt_out[i] = dval;
                  end
              end
              `QDURC_CMD_UPD_OUT:
              begin
                for (i = 0; i < 4; i = i + 1)
                  if (ch_hit(sel_ch, i))
                    nxt_out[i] = in_ff[i];
              end
              `QDURC_CMD_W_BOTH:
              begin
                for (i = 0; i < 4; i = i + 1)
                  if (ch_hit(sel_ch, i))
                  begin
                    nxt_in[i] = dval;
                    nxt_out[i] = dval;
                  end
              end
              `QDURC_CMD_MASK:
              begin
                nxt_mask = cmd_word[3:0];
              end
              `QDURC_CMD_SW_RESET:
              begin
                do_clear = 1'b1;
                nxt_mask = `QDURC_MASK_RESET;
                nxt_state = ST_POR;
              end
              default:
              begin
                nxt_mask = channel_load_mask_ff;
              end
            endcase
          end
        end
      end
      default:
      begin
        nxt_state = ST_POR;
      end
    endcase
    if (do_clear)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        nxt_in[i] = reset_code(sel_ff);
        nxt_out[i] = reset_code(sel_ff);
      end
    end
  end

  // state and reset busy flag
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      state_ff <= ST_POR;
      por_busy_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      por_busy_ff <= (nxt_state == ST_POR);
    end
  end

  always @(posedge clock)
  begin
    if (!rstn)
      channel_load_mask_ff <= `QDURC_MASK_RESET;
    else
      channel_load_mask_ff <= nxt_mask;
  end

  always @(posedge clock)
  begin
    if (!rstn)
      por_cnt_ff <= POR_CYC[7:0];
    else if (nxt_state == ST_POR && state_ff != ST_POR)
      por_cnt_ff <= POR_CYC[7:0];
    else if (state_ff == ST_POR && rst_ff && por_cnt_ff != 8'h00)
      por_cnt_ff <= por_cnt_ff - 8'h01;
  end

  // input and output pair per channel
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        in_ff[j] <= {DATA_W{1'b0}};
        out_ff[j] <= {DATA_W{1'b0}};
      end
    end
    else
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        in_ff[j] <= nxt_in[j];
        out_ff[j] <= nxt_out[j];
      end
    end
  end

  // port copies of the output registers
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      out_a_ff <= {DATA_W{1'b0}};
      out_b_ff <= {DATA_W{1'b0}};
      out_c_ff <= {DATA_W{1'b0}};
      out_d_ff <= {DATA_W{1'b0}};
    end
    else
    begin
      out_a_ff <= nxt_out[0];
      out_b_ff <= nxt_out[1];
      out_c_ff <= nxt_out[2];
      out_d_ff <= nxt_out[3];
    end
  end

endmodule

// >>> tb/qdurc_chk.sv
// Purpose: port checks for the update and reset control
// Assumes: pins held steady for several cycles
// Notes: bound to the control block
module qdurc_chk #(parameter DATA_W = 16) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [23:0] cmd_word,
  input wire logic cmd_valid,
  input wire logic load_strobe_n,
  input wire logic reset_n,
  input wire logic cmd_ready,
  input wire logic [DATA_W-1:0] out_a_ff,
  input wire logic [3:0] channel_load_mask_ff,
  input wire logic por_busy_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic [3:0] cmd = cmd_word[23:20];
  wire logic go = cmd_valid && cmd_ready;
  wire logic [DATA_W-1:0] dat = cmd_word[DATA_W-1:0];
  sequence s_lo; !load_strobe_n [*5]; endsequence
  sequence s_hi; load_strobe_n [*5]; endsequence
  property p_mask; go && cmd == 4'h5 |=> channel_load_mask_ff == $past(cmd_word[3:0]); endproperty
  a_mask: assert property (p_mask) else $error("mask load");
  property p_keep; !(go && cmd[2]) |=> $stable(channel_load_mask_ff); endproperty
  a_keep: assert property (p_keep) else $error("mask kept");
  property p_both; go && cmd == 4'h3 && cmd_word[16] |=> out_a_ff == $past(dat); endproperty
  a_both: assert property (p_both) else $error("write both");
  property p_lo; s_lo ##0 (go && cmd == 4'h1 && cmd_word[16]) |=> out_a_ff == $past(dat); endproperty
  a_lo: assert property (p_lo) else $error("direct update");
  property p_hi; s_hi ##0 (go && cmd == 4'h1 && cmd_word[16]) |=> $stable(out_a_ff); endproperty
  a_hi: assert property (p_hi) else $error("deferred update");
  property p_sw; go && cmd == 4'h6 |=> por_busy_ff && channel_load_mask_ff == 4'h0; endproperty
  a_sw: assert property (p_sw) else $error("soft reset");
  sequence s_rlo; !reset_n [*5]; endsequence
  property p_por; s_rlo ##0 por_busy_ff |=> por_busy_ff; endproperty
  a_por: assert property (p_por) else $error("ready in reset");
  property p_hold; !reset_n [*7] |-> !cmd_ready && $stable(out_a_ff); endproperty
  a_hold: assert property (p_hold) else $error("clear hold");
endmodule
bind qdurc_ctrl qdurc_chk #(.DATA_W(DATA_W)) u_qdurc_chk (.*);

// >>> tb/qdurc_host.sv
// Purpose: host model for command words and pins
// Assumes: bench waits for cmd_ready
// Notes: drives at the falling edge
module qdurc_host (
  input wire logic clock,
  output logic [23:0] cmd_word,
  output logic cmd_valid,
  output logic load_strobe_n,
  output logic reset_n,
  output logic reset_level_select
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_word = 24'h000000;
    cmd_valid = 1'b0;
    {load_strobe_n, reset_n, reset_level_select} = 3'h4;
  end
  task automatic send(input logic [23:0] w);
    @(negedge clock);
    cmd_word = w;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask
  task automatic pins(input logic [2:0] p);
    @(negedge clock);
    {load_strobe_n, reset_n, reset_level_select} = p;
    repeat (8) @(negedge clock);
  endtask
endmodule

// >>> tb/quad_dac_update_reset_control_test.sv
// Purpose: self-checking bench for the update and reset control
// Assumes: host model sources words and pins
// Notes: expectations from command codes and pin levels
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module quad_dac_update_reset_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn;
  wire [23:0] w;
  wire v, s, r, l, rdy, busy;
  wire [15:0] a, b, c, d;
  wire [3:0] m;
  int fails = 0;
  int compares = 0;
  qdurc_host u_qdurc_host (.clock(clock), .cmd_word(w), .cmd_valid(v), .load_strobe_n(s),
    .reset_n(r), .reset_level_select(l));
  qdurc_ctrl u_qdurc_ctrl (.clock(clock), .rstn(rstn), .cmd_word(w), .cmd_valid(v),
    .load_strobe_n(s), .reset_n(r), .reset_level_select(l), .cmd_ready(rdy), .out_a_ff(a),
    .out_b_ff(b), .out_c_ff(c), .out_d_ff(d), .channel_load_mask_ff(m), .por_busy_ff(busy));
  task automatic conclude;
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 200 && rdy !== 1'b1; n++)
      @(negedge clock);
    if (rdy !== 1'b1)
    begin
      fails++;
      conclude();
    end
  endtask
  task automatic put(input logic [23:0] x);
    wait_rdy();
    u_qdurc_host.send(x);
    repeat (2) @(negedge clock);
  endtask
  task automatic p(input logic [2:0] x);
    u_qdurc_host.pins(x);
  endtask
  task automatic outs(input logic [63:0] x);
    `CHK("outputs", x, {d, c, b, a})
  endtask
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    rstn = 1'b0;
    repeat (12) @(negedge clock);
    rstn = 1'b1;
    repeat (30) @(negedge clock);
    `CHK("busy", 1'b1, busy)
    p(3'h6);
    wait_rdy();
    outs(64'h0);
    `CHK("mask", 4'h0, m)
    put(24'h111234);
    outs(64'h0);
    p(3'h2);
    outs(64'h1234);
    p(3'h6);
    put(24'h5F0002);
    `CHK("mask", 4'h2, m)
    put(24'h125555);
    put(24'h116666);
    p(3'h2);
    outs(64'h6666);
    put(24'h220000);
    outs(64'h55556666);
    put(24'h317777);
    outs(64'h55557777);
    put(24'h500001);
    put(24'h114321);
    outs(64'h55554321);
    p(3'h7);
    p(3'h5);
    outs(64'h8000800080008000);
    `CHK("ready", 1'b0, rdy)
    p(3'h7);
    outs(64'h8000800080008000);
    put(24'h600000);
    `CHK("busy", 1'b1, busy)
    wait_rdy();
    outs(64'h8000800080008000);
    `CHK("mask", 4'h0, m)
    conclude();
  end
endmodule
